/* src/eio_timing.sv */
/*
 * external i/o bank timing: two timing registers on apb, and a memory
 * state machine that places select and strobe edges, stretched by wait.
 * assumes ext_wait_n is synchronous to pclk and released on a rising
 * edge of mem_clock_out; the access request holds until acc_done.
 */
// Register access over APB is this design's own decision.
`default_nettype none
module eio_timing
	import eio_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// access request from the memory controller
	input wire eio_req_s acc_req,
	output logic acc_done,
	// external pins
	input wire logic ext_wait_n,
	output eio_pins_s pins,
	output logic mem_clock_out
);
	typedef struct packed {
		logic [31:0] tim01;
		logic [31:0] tim23;
		logic rom5_wait_en;
		eio_state_e st;
		logic [2:0] cnt;
		logic wait_seen;
		logic [31:0] rdata;
		logic ready;
		logic err;
		logic done;
		eio_pins_s pins;
		logic mclk;
	} eio_regs_s;

	eio_regs_s q, d;

	// three-bit fields, read as cycle counts, with a zero acc or coh taken as one cycle
	// pick one bank's fields out of the two timing registers
	function automatic eio_timing_s bank_timing(input logic [31:0] t01,
			input logic [31:0] t23, input logic [1:0] bank);
		logic [31:0] w;
		logic [15:0] h;
		w = bank[1] ? t23 : t01;
		h = bank[0] ? w[EIO_POS_ODD +: 16] : w[15:0];
		bank_timing.cos = h[EIO_POS_COS +: EIO_FLD_W];
		bank_timing.acs = h[EIO_POS_ACS +: EIO_FLD_W];
		bank_timing.coh = h[EIO_POS_COH +: EIO_FLD_W];
		bank_timing.acc = h[EIO_POS_ACC +: EIO_FLD_W];
	endfunction

	// drive the strobe that matches the direction, keep the selects
	function automatic eio_pins_s with_strobe(input eio_pins_s p, input logic wr);
		with_strobe = p;
		with_strobe.out_strobe_n = wr;
		with_strobe.write_byte_strobe_n = !wr;
	endfunction

	eio_timing_s tm;
	logic apb_acc;
	logic wait_on;

	assign tm = bank_timing(q.tim01, q.tim23, acc_req.bank);
	assign apb_acc = psel && penable && !q.ready;
	// wait only counts for i/o banks or an enabled rom bank 5
	assign wait_on = !ext_wait_n && (!acc_req.rom5 || q.rom5_wait_en);

	// next-state logic for bus slave and memory state machine
	always_comb begin
		d = q;
		d.ready = 1'b0;
		d.err = 1'b0;
		d.done = 1'b0;
		d.mclk = ~q.mclk;
		// apb: one wait state, answer on second access cycle
		if (apb_acc) begin
			d.ready = 1'b1;
			case (paddr)
				EIO_OFS_TIM01: begin
					if (pwrite)
						d.tim01 = pwdata & EIO_FIELD_MASK;
					d.rdata = q.tim01;
				end
				EIO_OFS_TIM23: begin
					if (pwrite)
						d.tim23 = pwdata & EIO_FIELD_MASK;
					d.rdata = q.tim23;
				end
				EIO_OFS_CTRL: begin
					if (pwrite)
						d.rom5_wait_en = pwdata[EIO_CTRL_ROM5_WAIT];
					d.rdata = {31'h00000000, q.rom5_wait_en};
				end
				EIO_OFS_STAT: begin
					d.rdata = {28'h0000000, q.wait_seen, q.st == EIO_IDLE ? 1'b0 : 1'b1,
						acc_req.bank};
				end
				// bank 0 base pointer register is not decoded here
				default: begin
					d.rdata = 32'h00000000;
					d.err = 1'b1;
				end
			endcase
		end
		// memory state machine
		case (q.st)
			EIO_IDLE: begin
				d.pins = '{1'b1, 1'b1, 1'b1, 1'b1};
				d.wait_seen = 1'b0;
				if (acc_req.req) begin
					if (acc_req.rom5) begin
						// select and strobe together for rom bank 5
						d.pins.rom_select_n = 1'b0;
						d.pins.out_strobe_n = acc_req.write;
						d.pins.write_byte_strobe_n = !acc_req.write;
						d.cnt = 3'h1;
						d.st = EIO_WAIT;
					end else if (tm.acs != 3'h0) begin
						d.cnt = tm.acs;
						d.st = EIO_ADDR;
					end else begin
						d.pins.io_select_n = 1'b0;
						d.cnt = tm.cos;
						d.st = EIO_SETUP;
						// a zero setup count puts strobe with select
						if (tm.cos == 3'h0) begin
							d.pins = with_strobe(d.pins, acc_req.write);
							d.cnt = tm.acc;
							d.st = EIO_STROBE;
						end
					end
				end
			end
			EIO_ADDR: begin
				d.cnt = q.cnt - 3'h1;
				if (q.cnt == 3'h1) begin
					d.pins.io_select_n = 1'b0;
					d.cnt = tm.cos;
					d.st = EIO_SETUP;
					// a zero setup count puts strobe with select
					if (tm.cos == 3'h0) begin
						d.pins = with_strobe(d.pins, acc_req.write);
						d.cnt = tm.acc;
						d.st = EIO_STROBE;
					end
				end
			end
			// strobe held back by the setup count
			EIO_SETUP: begin
				if (q.cnt <= 3'h1) begin
					d.pins.out_strobe_n = acc_req.write;
					d.pins.write_byte_strobe_n = !acc_req.write;
					d.cnt = tm.acc;
					d.st = EIO_STROBE;
				end else begin
					d.cnt = q.cnt - 3'h1;
				end
			end
			// wait sampled once the strobe is low
			EIO_STROBE: begin
				if (wait_on) begin
					d.wait_seen = 1'b1;
					d.st = EIO_WAIT;
				end else if (q.cnt <= 3'h1) begin
					d.pins.out_strobe_n = 1'b1;
					d.pins.write_byte_strobe_n = 1'b1;
					d.cnt = tm.coh;
					d.st = EIO_HOLD;
				end else begin
					d.cnt = q.cnt - 3'h1;
				end
			end
			EIO_WAIT: begin
				if (wait_on) begin
					d.wait_seen = 1'b1;
				end else if (q.cnt != 3'h0) begin
					d.cnt = q.cnt - 3'h1;
				end else begin
					d.pins.out_strobe_n = 1'b1;
					d.pins.write_byte_strobe_n = 1'b1;
					d.pins.rom_select_n = acc_req.rom5 ? 1'b1 : q.pins.rom_select_n;
					d.cnt = acc_req.rom5 ? 3'h0 : tm.coh;
					d.st = EIO_HOLD;
				end
			end
			EIO_HOLD: begin
				if (q.cnt <= 3'h1) begin
					d.pins = '{1'b1, 1'b1, 1'b1, 1'b1};
					d.done = 1'b1;
					d.st = EIO_DONE;
				end else begin
					d.cnt = q.cnt - 3'h1;
				end
			end
			EIO_DONE: begin
				d.st = EIO_IDLE;
			end
			default: begin
				d.st = EIO_IDLE;
			end
		endcase
	end

	// register the whole state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q.tim01 <= EIO_RST_TIM;
			q.tim23 <= EIO_RST_TIM;
			q.rom5_wait_en <= EIO_RST_CTRL[EIO_CTRL_ROM5_WAIT];
			q.st <= EIO_IDLE;
			q.cnt <= 3'h0;
			q.wait_seen <= 1'b0;
			q.rdata <= 32'h00000000;
			q.ready <= 1'b0;
			q.err <= 1'b0;
			q.done <= 1'b0;
			q.pins <= '{1'b1, 1'b1, 1'b1, 1'b1};
			q.mclk <= 1'b0;
		end else begin
			q <= d;
		end
	end

	// outputs straight from flops
	assign prdata = q.rdata;
	assign pready = q.ready;
	assign pslverr = q.err;
	assign acc_done = q.done;
	assign pins = q.pins;
	assign mem_clock_out = q.mclk;

	// rom bank 5 select and strobe fall together
	rom5_together_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(pins.rom_select_n) |-> !pins.out_strobe_n || !pins.write_byte_strobe_n)
		else $error("rom select fell without strobe");
	strobe_after_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(pins.out_strobe_n) && pins.rom_select_n |-> !pins.io_select_n)
		else $error("strobe active without select");
	// register write lands in banks 0/1 register
	tim01_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		apb_acc && pwrite && paddr == EIO_OFS_TIM01 |=> q.tim01 == ($past(pwdata) & EIO_FIELD_MASK))
		else $error("timing register 0 not written");
	// register write lands in banks 2/3 register
	tim23_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		apb_acc && pwrite && paddr == EIO_OFS_TIM23 |=> q.tim23 == ($past(pwdata) & EIO_FIELD_MASK))
		else $error("timing register 1 not written");
	// strobe stays low while in wait
	wait_holds_a: assert property (@(posedge pclk) disable iff (!presetn)
		q.st == EIO_WAIT && wait_on |=> q.st == EIO_WAIT
			&& !(pins.out_strobe_n && pins.write_byte_strobe_n))
		else $error("wait did not stretch access");
	wait_ignored_a: assert property (@(posedge pclk) disable iff (!presetn)
		acc_req.rom5 && !q.rom5_wait_en && q.st == EIO_WAIT && q.cnt == 3'h0 |=> q.st == EIO_HOLD)
		else $error("wait honoured while disabled");
	setup_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
		q.st == EIO_SETUP && q.cnt > 3'h1 |=> q.st == EIO_SETUP && pins.out_strobe_n
			&& pins.write_byte_strobe_n)
		else $error("strobe asserted early");
	// apb answers in one wait state
	apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable ##1 psel && penable |=> pready)
		else $error("apb answer late");
	// zero setup count drops select and strobe together
	zero_setup_a: assert property (@(posedge pclk) disable iff (!presetn)
		q.st == EIO_IDLE && acc_req.req && !acc_req.rom5 && tm.acs == 3'h0 && tm.cos == 3'h0
			|=> !pins.io_select_n && !(pins.out_strobe_n && pins.write_byte_strobe_n))
		else $error("zero setup strobe late");
	// select held through the hold count
	hold_select_a: assert property (@(posedge pclk) disable iff (!presetn)
		q.st == EIO_HOLD && q.cnt > 3'h1 |=> !pins.io_select_n && pins.out_strobe_n
			&& pins.write_byte_strobe_n)
		else $error("select released before hold count");
	// access end marked by a single pulse
	done_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		acc_done |=> !acc_done)
		else $error("access done pulse too long");
endmodule
`default_nettype wire

/* src/eio_pkg.sv */
/*
 * package for the external i/o bank timing block: register offsets,
 * field positions, reset values, states and carrier structs.
 * assumes a 32-bit apb register bus and a single system clock.
 */
`default_nettype none
package eio_pkg;
	localparam logic [15:0] EIO_OFS_TIM01 = 16'h3008;
	localparam logic [15:0] EIO_OFS_TIM23 = 16'h300C;
	localparam logic [15:0] EIO_OFS_CTRL = 16'h3040;
	localparam logic [15:0] EIO_OFS_STAT = 16'h3044;
	localparam logic [31:0] EIO_RST_TIM = 32'h00000000;
	localparam logic [31:0] EIO_RST_CTRL = 32'h00000000;
	localparam logic [31:0] EIO_FIELD_MASK = 32'h0FFF0FFF;
	// field positions within one bank half, the odd half's offset in the register and the field width
	localparam int EIO_POS_COS = 0;
	localparam int EIO_POS_ACS = 3;
	localparam int EIO_POS_COH = 6;
	localparam int EIO_POS_ACC = 9;
	localparam int EIO_POS_ODD = 16;
	localparam int EIO_FLD_W = 3;
	// control register bit
	localparam int EIO_CTRL_ROM5_WAIT = 0;

	typedef enum {
		EIO_IDLE, EIO_ADDR, EIO_SETUP, EIO_STROBE, EIO_WAIT, EIO_HOLD, EIO_DONE
	} eio_state_e;

	typedef struct packed {
		logic [2:0] cos;
		logic [2:0] acs;
		logic [2:0] coh;
		logic [2:0] acc;
	} eio_timing_s;

	typedef struct packed {
		logic req;
		logic write;
		logic rom5;
		logic [1:0] bank;
	} eio_req_s;

	typedef struct packed {
		logic io_select_n;
		logic rom_select_n;
		logic out_strobe_n;
		logic write_byte_strobe_n;
	} eio_pins_s;
endpackage
`default_nettype wire

/* verification/eio_periph.sv */
/* external i/o peripheral model: stretches an access by holding wait low.
   assumes the bench sets the stretch length before the access starts. */
`default_nettype none
module eio_periph
	import eio_pkg::*;
(
	// clock and observed pins
	input wire logic pclk,
	input wire eio_pins_s pins,
	input wire logic mem_clock_out,
	// stretch length in cycles, zero for none
	input wire logic [3:0] stall,
	// wait output, pulled up while idle
	output logic ext_wait_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic strobe_on;
	assign strobe_on = !(pins.out_strobe_n && pins.write_byte_strobe_n);
	initial begin
		ext_wait_n = 1'b1;
		forever begin
			@(negedge pclk);
			if (strobe_on && stall != 4'h0) begin
				ext_wait_n = 1'b0;
				repeat (stall) @(posedge pclk);
				@(posedge mem_clock_out);
				ext_wait_n = 1'b1;
				while (strobe_on) @(negedge pclk);
			end
		end
	end
endmodule
`default_nettype wire

/* verification/eio_timing_test.sv */
/* bench for the i/o bank timing block: register access and timed accesses.
   assumes eio_periph drives the wait input. */
`default_nettype none
module eio_timing_test
	import eio_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, acc_done, ext_wait_n, mclk;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic err, sel_on, stb_on, m0;
	logic [3:0] stall;
	eio_req_s acc_req;
	eio_pins_s pins;
	int bad_count, tests_run, n, a, w, h, w0;
	eio_timing u_eio_timing (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .acc_req(acc_req), .acc_done(acc_done), .ext_wait_n(ext_wait_n),
		.pins(pins), .mem_clock_out(mclk));
	eio_periph u_eio_periph (.pclk(pclk), .pins(pins), .mem_clock_out(mclk), .stall(stall),
		.ext_wait_n(ext_wait_n));
	// active select and strobe of the current access
	assign sel_on = !(acc_req.rom5 ? pins.rom_select_n : pins.io_select_n);
	assign stb_on = !(acc_req.write ? pins.write_byte_strobe_n : pins.out_strobe_n);
	// 20 MHz clock
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// apb master, holds the request until pready
	task automatic apb(input logic wr, input logic [15:0] ad, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// counts cycles while select or strobe stays at level v
	task automatic span(input bit s, input bit v, output int c);
		c = 0;
		while (((s ? sel_on : stb_on) === v) && c < 60) begin
			c++;
			@(negedge pclk);
		end
	endtask
	// one access, measured at falling edges
	task automatic acc(input logic wr, input logic r5, input logic [1:0] b);
		@(posedge pclk);
		acc_req <= '{req: 1'b1, write: wr, rom5: r5, bank: b};
		@(negedge pclk);
		span(1'b1, 1'b0, n);
		span(1'b0, 1'b0, a);
		span(1'b0, 1'b1, w);
		span(1'b1, 1'b1, h);
		// rom bank 5 ends one cycle after its select rises
		if (r5)
			@(negedge pclk);
		chk(acc_done, 1'b1);
		@(posedge pclk);
		acc_req.req <= 1'b0;
	endtask
	// timing half for bank b: acc, hold, addr setup, strobe setup
	function automatic logic [11:0] mk(input int b);
		mk = {3'(7 - b), 3'(b + 1), 3'(b), 3'(b + 2)};
	endfunction
	task automatic t_regs();
		apb(1'b0, EIO_OFS_TIM01, 32'h0);
		chk(rd, EIO_RST_TIM);
		apb(1'b0, EIO_OFS_TIM23, 32'h0);
		chk(rd, EIO_RST_TIM);
		apb(1'b0, 16'h303C, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		apb(1'b1, EIO_OFS_TIM01, {4'hF, mk(1), 4'hF, mk(0)});
		apb(1'b1, EIO_OFS_TIM23, {4'hF, mk(3), 4'hF, mk(2)});
		apb(1'b0, EIO_OFS_TIM01, 32'h0);
		chk(rd, {4'h0, mk(1), 4'h0, mk(0)});
		apb(1'b0, EIO_OFS_TIM23, 32'h0);
		chk(rd, {4'h0, mk(3), 4'h0, mk(2)});
		// memory clock runs at half the system clock
		@(negedge pclk);
		m0 = mclk;
		@(negedge pclk);
		chk(mclk, !m0);
	endtask
	task automatic t_banks();
		for (int b = 0; b < 4; b++) begin
			acc(b[0], 1'b0, 2'(b));
			chk(n, b + 1);
			chk(a, b + 2);
			chk(w, 7 - b);
			chk(h, b + 1);
		end
	endtask
	task automatic t_wait();
		for (int b = 0; b < 4; b += 3) begin
			stall <= 4'h3;
			acc(1'b0, 1'b0, 2'(b));
			chk(w > 7 - b, 1'b1);
			chk(a, b + 2);
		end
		stall <= 4'h0;
	endtask
	task automatic t_rom5();
		apb(1'b1, EIO_OFS_CTRL, 32'h0);
		acc(1'b0, 1'b1, 2'd0);
		w0 = w;
		chk(a, 0);
		stall <= 4'h3;
		acc(1'b0, 1'b1, 2'd0);
		chk(w, w0);
		apb(1'b1, EIO_OFS_CTRL, 32'h1);
		apb(1'b0, EIO_OFS_CTRL, 32'h0);
		chk(rd, 32'h1);
		acc(1'b0, 1'b1, 2'd0);
		chk(a, 0);
		chk(w > w0, 1'b1);
		stall <= 4'h0;
	endtask
	// zero setup count: select and strobe together
	task automatic t_zero();
		apb(1'b1, EIO_OFS_TIM01, 32'h00000240);
		acc(1'b0, 1'b0, 2'd0);
		chk(n, 1);
		chk(a, 0);
		chk(w, 1);
		chk(h, 1);
	endtask
	// watchdog
	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		print_verdict();
	end
	// reset then scenarios
	initial begin
		bad_count = 0;
		tests_run = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 16'h0000;
		pwdata = 32'h00000000;
		acc_req = '0;
		stall = 4'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_banks();
		t_wait();
		t_rom5();
		t_zero();
		print_verdict();
	end
endmodule
`default_nettype wire
